// >>> rtl/uic_bus_collision.sv
// Purpose: UART channel in bus collision mode, one 9-bit character per emulated bus bit
// Assumes: APB slave, zero wait states; pins synchronised here
// Notes: CHANNEL picks collision gating and pin behaviour per channel index
// Behaviour
// [RULE_01] One whole async character stands for one bit of the shared bus.
// [RULE_02] Driven transmit level differing from received level raises the collision request.
// [RULE_03] Channels 0 and 1 detect collisions only with their enable bit set.
// [RULE_04] Frame is start bit, nine data bits LSB first, then stop bit.
// [RULE_05] Transmit and receive buffers each hold nine data bits.
// [RULE_06] Sample select 0 compares levels at each transfer clock rising edge.
// [RULE_07] Sample select 1 compares at the one-shot timer underflow, pin triggered.
// [RULE_08] Timer for channel 0, 1, 2 is the one tied to that channel.
// [RULE_09] Auto disable set clears transmit enable when collision flag sets.
// [RULE_10] Start select 0 sends start bit one transfer clock after enable condition.
// [RULE_11] Start select 1 sends at active receive edge, falling normally, rising inverted.
// [RULE_12] Software meets the transmit condition before the launching receive edge.
// [RULE_13] Polarity bit inverts both transmit output and receive input.
// [RULE_14] Baud divider counts the selected internal or external source clock.
// [RULE_15] Transmit only with transmit enable, receive only with receive enable.
// [RULE_16] Flags show transmit buffer empty, shift register empty, reception complete.
// [RULE_17] Transmit interrupt source bit chooses buffer empty or transmission complete.
// [RULE_18] Channel 2 output always open drain; others select by output mode bit.
// [RULE_19] Software writes zero to every unassigned register bit.
// [RULE_20] One stop bit, no parity, no flow control in this mode.
// [RULE_21] Overrun flags when last data bit arrives while previous data unread.
// [RULE_22] Error sum reads one when overrun, framing or parity error is set.
`timescale 1ns/1ps
`default_nettype none
module uic_bus_collision
  import uic_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter int ONESHOT_COUNT = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialRxPin,
  input wire logic serialClockPin,
  input wire logic timerTriggerInput,
  output logic serialTxPinO,
  output logic serialTxPinOe,
  output logic collisionIrq,
  output logic txIrq,
  output logic rxIrq
);
  if (CHANNEL < 0 || CHANNEL > 2) begin : g_bad_channel
    $error("CHANNEL must be 0, 1 or 2");
  end
  localparam logic IS_CH2 = (CHANNEL == 2);

  uic_cfg_s cfg, next_cfg;
  uic_flags_s flags, next_flags;
  uic_tx_e txState, next_txState;
  uic_rx_e rxState, next_rxState;
  logic [8:0] txBuffer, next_txBuffer, rxBuffer, next_rxBuffer;
  logic [8:0] txShift, next_txShift, rxShift, next_rxShift;
  logic [7:0] baudDivider, next_baudDivider;
  logic [3:0] txBitCnt, next_txBitCnt, rxBitCnt, next_rxBitCnt;
  logic [3:0] freePhase, next_freePhase, rxPhase, next_rxPhase;
  logic txEnableBit, next_txEnableBit, txLevel, next_txLevel;
  logic next_txIrq, next_rxIrq, next_pinO, next_pinOe;
  logic [2:0] pinMeta, pinSync;
  logic rxPrev, rxLogic, rxActiveEdge, tick16, timerUnderflow, bitTick;
  logic wrEn, rdEn, addrHit, txLoad, txDone, rxDone, overrunEvent, collisionSet;
  logic [31:0] rdValue;

  // Two-stage sync of {trigger, clock pin, rx}; only pinSync is looked at
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // Trigger and clock pin start low like their edge detectors, so reset makes no false edge
      pinMeta <= 3'h1;
      pinSync <= 3'h1;
      rxPrev <= 1'b1;
    end else begin
      pinMeta <= {timerTriggerInput, serialClockPin, serialRxPin};
      pinSync <= pinMeta;
      rxPrev <= pinSync[0];
    end
  end

  // Logical receive level and its active edge [RULE_13] [RULE_11]
  assign rxLogic = pinSync[0] ^ cfg.linePolarityInvert;
  assign rxActiveEdge = (rxPrev ^ cfg.linePolarityInvert) && !rxLogic;

  // The timer instance belongs to this channel only [RULE_08]
  uic_timing #(.ONESHOT_COUNT(ONESHOT_COUNT)) u_timing (
    .clk(clk),
    .rst_b(rst_b),
    .countSourceSelect(cfg.countSourceSelect),
    .clockDirection(cfg.clockDirection),
    .baudDivider(baudDivider),
    .extClockSync(pinSync[1]),
    .triggerSync(pinSync[2]),
    .tick16(tick16),
    .timerUnderflow(timerUnderflow)
  );

  // Transfer clock rising edge marks each bit boundary
  assign bitTick = tick16 && (freePhase == PHASE_LAST);

  // Collision compare moment, gate and mismatch [RULE_02] [RULE_03] [RULE_06] [RULE_07]
  always_comb begin
    collisionSet = (cfg.collisionSampleSelect ? timerUnderflow : bitTick)
      && (cfg.serialModeSelect == MODE_BUS_COLL)
      && (IS_CH2 || cfg.collisionDetectEnable)
      && (txState inside {TX_START, TX_DATA, TX_STOP})
      && (txLevel != rxLogic);
  end

  // APB decode; zero wait states, unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  always_comb begin
    addrHit = (paddr inside {OFF_TXBUF, OFF_RXBUF, OFF_BAUD, OFF_MODE, OFF_CTRL0,
                             OFF_CTRL1, OFF_SPECIAL, OFF_IRQSEL, OFF_STATUS});
    pslverr = psel && penable && !addrHit;
    rdValue = 32'h0000_0000;
    unique case (paddr)
      OFF_TXBUF: rdValue[8:0] = txBuffer;
      OFF_RXBUF: begin
        rdValue[8:0] = rxBuffer; // Nine data bits [RULE_05]
        rdValue[RB_OVERRUN] = flags.overrunError;
        rdValue[RB_FRAMING] = flags.framingError;
        rdValue[RB_PARITY] = 1'b0;
        rdValue[RB_SUM] = flags.overrunError || flags.framingError; // [RULE_22]
      end
      OFF_BAUD: rdValue[7:0] = baudDivider;
      OFF_MODE: begin
        rdValue[MODE_SMD_LSB +: 3] = cfg.serialModeSelect;
        rdValue[MODE_CLOCK_DIRECTION] = cfg.clockDirection;
        rdValue[MODE_STOP] = cfg.stopBitLength;
        rdValue[MODE_PAR] = cfg.parityEnableBit;
        rdValue[MODE_POL] = cfg.linePolarityInvert;
      end
      OFF_CTRL0: begin
        rdValue[C0_CS_LSB +: 2] = cfg.countSourceSelect;
        rdValue[C0_SHIFT_EMPTY] = (txState == TX_IDLE); // [RULE_16]
        rdValue[C0_FLOW_DIS] = cfg.flowControlDisable;
        rdValue[C0_OUT_MODE] = cfg.txOutputMode && !IS_CH2;
      end
      OFF_CTRL1: begin
        rdValue[C1_TX_EN] = txEnableBit;
        rdValue[C1_TX_EMPTY] = flags.txBufferEmpty; // [RULE_16]
        rdValue[C1_RX_EN] = cfg.rxEnableBit;
        rdValue[C1_RX_DONE] = flags.rxComplete; // [RULE_16]
      end
      OFF_SPECIAL: begin
        rdValue[SP_SAMPLE_SEL] = cfg.collisionSampleSelect;
        rdValue[SP_AUTO_DIS] = cfg.autoTxDisableEnable;
        rdValue[SP_START_SYNC] = cfg.txStartSyncSelect;
      end
      OFF_IRQSEL: begin
        rdValue[IS_TX_SRC] = cfg.txIrqSource;
        rdValue[IS_COLL_EN] = cfg.collisionDetectEnable;
      end
      OFF_STATUS: rdValue[ST_COLL] = flags.collision;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdValue;
    end
  end

  // Software registers and hardware flags
  always_comb begin
    next_cfg = cfg;
    next_flags = flags;
    next_txBuffer = txBuffer;
    next_rxBuffer = rxBuffer;
    next_baudDivider = baudDivider;
    next_txEnableBit = txEnableBit;
    if (txLoad) begin
      next_flags.txBufferEmpty = 1'b1;
    end
    if (wrEn) begin
      unique case (paddr)
        OFF_TXBUF: begin
          next_txBuffer = pwdata[8:0]; // [RULE_05]
          next_flags.txBufferEmpty = 1'b0;
        end
        OFF_BAUD: next_baudDivider = pwdata[7:0];
        OFF_MODE: begin
          next_cfg.serialModeSelect = pwdata[MODE_SMD_LSB +: 3];
          next_cfg.clockDirection = pwdata[MODE_CLOCK_DIRECTION];
          next_cfg.stopBitLength = pwdata[MODE_STOP];
          next_cfg.parityEnableBit = pwdata[MODE_PAR];
          next_cfg.linePolarityInvert = pwdata[MODE_POL];
        end
        OFF_CTRL0: begin
          next_cfg.countSourceSelect = pwdata[C0_CS_LSB +: 2];
          next_cfg.flowControlDisable = pwdata[C0_FLOW_DIS];
          next_cfg.txOutputMode = pwdata[C0_OUT_MODE];
        end
        OFF_CTRL1: begin
          next_txEnableBit = pwdata[C1_TX_EN];
          next_cfg.rxEnableBit = pwdata[C1_RX_EN];
          if (!pwdata[C1_RX_EN]) begin
            next_flags.overrunError = 1'b0;
          end
        end
        OFF_SPECIAL: begin
          next_cfg.collisionSampleSelect = pwdata[SP_SAMPLE_SEL];
          next_cfg.autoTxDisableEnable = pwdata[SP_AUTO_DIS];
          next_cfg.txStartSyncSelect = pwdata[SP_START_SYNC];
        end
        OFF_IRQSEL: begin
          next_cfg.txIrqSource = pwdata[IS_TX_SRC];
          next_cfg.collisionDetectEnable = pwdata[IS_COLL_EN];
        end
        OFF_STATUS: begin
          if (pwdata[ST_COLL]) begin
            next_flags.collision = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rdEn && paddr == OFF_RXBUF) begin
      next_flags.rxComplete = 1'b0;
    end
    // Hardware events come last so a set beats a same-cycle clear
    if (rxDone) begin
      next_rxBuffer = rxShift;
      next_flags.rxComplete = 1'b1; // [RULE_16]
      next_flags.framingError = !rxLogic;
    end
    if (overrunEvent) begin
      next_flags.overrunError = 1'b1; // [RULE_21]
    end
    if (collisionSet) begin
      next_flags.collision = 1'b1; // [RULE_02]
      if (cfg.autoTxDisableEnable) begin
        next_txEnableBit = 1'b0; // Beats a same-cycle software set [RULE_09]
      end
    end
    next_txIrq = cfg.txIrqSource ? txDone : txLoad; // [RULE_17]
    next_rxIrq = rxDone;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg <= CFG_RST;
      flags <= FLAGS_RST;
      txBuffer <= DATA_RST;
      rxBuffer <= DATA_RST;
      baudDivider <= BAUD_RST;
      txEnableBit <= 1'b0;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      flags <= next_flags;
      txBuffer <= next_txBuffer;
      rxBuffer <= next_rxBuffer;
      baudDivider <= next_baudDivider;
      txEnableBit <= next_txEnableBit;
      txIrq <= next_txIrq;
      rxIrq <= next_rxIrq;
    end
  end
  assign collisionIrq = flags.collision;

  // Transmitter: one stop bit, no parity, no flow control [RULE_20] [RULE_01]
  always_comb begin
    next_txState = txState;
    next_txShift = txShift;
    next_txBitCnt = txBitCnt;
    next_freePhase = tick16 ? 4'(freePhase + 4'h1) : freePhase;
    txLoad = 1'b0;
    txDone = 1'b0;
    unique case (txState)
      TX_IDLE: begin
        if (txEnableBit && !flags.txBufferEmpty) begin // [RULE_15]
          txLoad = 1'b1;
          next_txShift = txBuffer;
          next_txState = TX_ARM;
        end
      end
      TX_ARM: begin
        if (!cfg.txStartSyncSelect) begin
          if (bitTick) begin
            next_txState = TX_START; // [RULE_10]
          end
        end else if (rxActiveEdge) begin
          next_txState = TX_START; // Edge also realigns the transfer clock [RULE_11]
          next_freePhase = PHASE_ZERO;
        end
      end
      TX_START: begin
        if (bitTick) begin
          next_txState = TX_DATA;
          next_txBitCnt = BIT_FIRST;
        end
      end
      TX_DATA: begin
        if (bitTick) begin
          next_txShift = {1'b0, txShift[8:1]}; // LSB first [RULE_04]
          if (txBitCnt == BIT_LAST) begin
            next_txState = TX_STOP;
          end else begin
            next_txBitCnt = 4'(txBitCnt + 4'h1);
          end
        end
      end
      TX_STOP: begin
        if (bitTick) begin
          next_txState = TX_IDLE;
          txDone = 1'b1;
        end
      end
    endcase
    next_txLevel = (next_txState == TX_START) ? 1'b0 :
                   (next_txState == TX_DATA) ? next_txShift[0] : 1'b1;
    next_pinO = next_txLevel ^ cfg.linePolarityInvert; // [RULE_13]
    // Open drain only pulls low; channel 2 has no push-pull choice [RULE_18]
    next_pinOe = (IS_CH2 || cfg.txOutputMode) ? !next_pinO : 1'b1;
  end

  // Pin drivers start released so nothing fights the bus during reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txState <= TX_IDLE;
      txShift <= DATA_RST;
      txBitCnt <= BIT_FIRST;
      freePhase <= PHASE_ZERO;
      txLevel <= 1'b1;
      serialTxPinO <= 1'b1;
      serialTxPinOe <= 1'b0;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txBitCnt <= next_txBitCnt;
      freePhase <= next_freePhase;
      txLevel <= next_txLevel;
      serialTxPinO <= next_pinO;
      serialTxPinOe <= next_pinOe;
    end
  end

  // Receiver: samples at mid bit, aborts when disabled [RULE_15]
  always_comb begin
    next_rxState = rxState;
    next_rxShift = rxShift;
    next_rxBitCnt = rxBitCnt;
    next_rxPhase = (tick16 && rxState != RX_IDLE) ? 4'(rxPhase + 4'h1) : rxPhase;
    rxDone = 1'b0;
    overrunEvent = 1'b0;
    if (rxState == RX_IDLE) begin
      if (cfg.rxEnableBit && rxActiveEdge) begin
        next_rxState = RX_START;
        next_rxPhase = PHASE_ZERO;
      end
    end else if (!cfg.rxEnableBit) begin
      next_rxState = RX_IDLE;
    end else if (tick16 && rxPhase == PHASE_MID) begin
      if (rxState == RX_START) begin
        next_rxState = rxLogic ? RX_IDLE : RX_DATA; // Glitch rejection
        next_rxBitCnt = BIT_FIRST;
      end else if (rxState == RX_DATA) begin
        next_rxShift = {rxLogic, rxShift[8:1]};
        if (rxBitCnt == BIT_LAST) begin
          next_rxState = RX_STOP;
          overrunEvent = flags.rxComplete; // [RULE_21]
        end else begin
          next_rxBitCnt = 4'(rxBitCnt + 4'h1);
        end
      end else begin
        next_rxState = RX_IDLE;
        rxDone = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxState <= RX_IDLE;
      rxShift <= DATA_RST;
      rxBitCnt <= BIT_FIRST;
      rxPhase <= PHASE_ZERO;
    end else begin
      rxState <= next_rxState;
      rxShift <= next_rxShift;
      rxBitCnt <= next_rxBitCnt;
      rxPhase <= next_rxPhase;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence sArmed;
    txState == TX_ARM;
  endsequence
  sequence sStartBit;
    txState == TX_START && !txLevel;
  endsequence
  a_coll_sets: assert property (collisionSet |=> flags.collision) else $error("collision flag not set"); // [RULE_02]
  a_coll_gate: assert property (!IS_CH2 && !cfg.collisionDetectEnable |-> !collisionSet) else $error("gated collision"); // [RULE_03]
  a_frame_end: assert property (txState == TX_DATA && bitTick && txBitCnt == BIT_LAST |=> txState == TX_STOP && txLevel)
    else $error("stop bit not after nine data bits"); // [RULE_04]
  a_sample_clk: assert property (collisionSet && !cfg.collisionSampleSelect |-> bitTick) else $error("compare off edge"); // [RULE_06]
  a_sample_tmr: assert property (collisionSet && cfg.collisionSampleSelect |-> timerUnderflow) else $error("compare off timer"); // [RULE_07]
  a_auto_clear: assert property (collisionSet && cfg.autoTxDisableEnable |=> !txEnableBit) else $error("enable not cleared"); // [RULE_09]
  a_start_tick: assert property (sArmed ##0 (!cfg.txStartSyncSelect && bitTick) |=> sStartBit) else $error("late start"); // [RULE_10]
  a_start_edge: assert property (sArmed ##0 (cfg.txStartSyncSelect && rxActiveEdge) |=> sStartBit) else $error("edge start"); // [RULE_11]
  // Pin flops follow the mode bit one cycle late, so the check uses the mode they were built from
  a_open_drain: assert property ((IS_CH2 || $past(cfg.txOutputMode)) && serialTxPinOe |-> !serialTxPinO) // [RULE_18]
    else $error("drives high");
  a_tx_gate: assert property (txState == TX_IDLE && !txEnableBit |=> txState == TX_IDLE) else $error("sent while disabled"); // [RULE_15]
endmodule
`default_nettype wire

// >>> rtl/uic_pkg.sv
// Purpose: Shared constants, field layouts and types for the bus collision UART channel
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Field positions are bit indices inside each register word
package uic_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_TXBUF = 8'h00;
  localparam logic [7:0] OFF_RXBUF = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_CTRL0 = 8'h10;
  localparam logic [7:0] OFF_CTRL1 = 8'h14;
  localparam logic [7:0] OFF_SPECIAL = 8'h18;
  localparam logic [7:0] OFF_IRQSEL = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // Mode register fields
  localparam int MODE_SMD_LSB = 0;
  localparam int MODE_CLOCK_DIRECTION = 3;
  localparam int MODE_STOP = 4;
  localparam int MODE_PAR = 6;
  localparam int MODE_POL = 7;
  // Control 0 fields
  localparam int C0_CS_LSB = 0;
  localparam int C0_SHIFT_EMPTY = 3;
  localparam int C0_FLOW_DIS = 4;
  localparam int C0_OUT_MODE = 5;
  // Control 1 fields
  localparam int C1_TX_EN = 0;
  localparam int C1_TX_EMPTY = 1;
  localparam int C1_RX_EN = 2;
  localparam int C1_RX_DONE = 3;
  // Special mode fields
  localparam int SP_SAMPLE_SEL = 4;
  localparam int SP_AUTO_DIS = 5;
  localparam int SP_START_SYNC = 6;
  // Interrupt source select fields
  localparam int IS_TX_SRC = 0;
  localparam int IS_COLL_EN = 1;
  // Receive buffer error fields and status
  localparam int RB_OVERRUN = 12;
  localparam int RB_FRAMING = 13;
  localparam int RB_PARITY = 14;
  localparam int RB_SUM = 15;
  localparam int ST_COLL = 0;
  // Mode code and timing
  localparam logic [2:0] MODE_BUS_COLL = 3'h6;
  localparam logic [3:0] PHASE_ZERO = 4'h0;
  localparam logic [3:0] PHASE_MID = 4'h7;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] CS_F1 = 2'h0;
  localparam logic [1:0] CS_F8 = 2'h1;
  localparam logic [1:0] CS_F32 = 2'h2;
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1F;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [8:0] DATA_RST = 9'h000;

  typedef enum logic [2:0] {TX_IDLE, TX_ARM, TX_START, TX_DATA, TX_STOP} uic_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uic_rx_e;

  typedef struct packed {
    logic [2:0] serialModeSelect;
    logic clockDirection;
    logic stopBitLength;
    logic parityEnableBit;
    logic linePolarityInvert;
    logic [1:0] countSourceSelect;
    logic flowControlDisable;
    logic txOutputMode;
    logic rxEnableBit;
    logic collisionSampleSelect;
    logic autoTxDisableEnable;
    logic txStartSyncSelect;
    logic txIrqSource;
    logic collisionDetectEnable;
  } uic_cfg_s;

  typedef struct packed {
    logic txBufferEmpty;
    logic rxComplete;
    logic overrunError;
    logic framingError;
    logic collision;
  } uic_flags_s;

  localparam uic_cfg_s CFG_RST = '0;
  localparam uic_flags_s FLAGS_RST = 5'h10;
endpackage

// >>> rtl/uic_timing.sv
// Purpose: Count source prescaler, baud divider and one-shot collision timer
// Assumes: Clock pin and trigger pin arrive already synchronised
// Notes: tick16 is the 16x oversampling enable; one bit lasts 16 ticks
`timescale 1ns/1ps
`default_nettype none
module uic_timing
  import uic_pkg::*;
#(
  parameter int ONESHOT_COUNT = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] countSourceSelect,
  input wire logic clockDirection,
  input wire logic [7:0] baudDivider,
  input wire logic extClockSync,
  input wire logic triggerSync,
  output logic tick16,
  output logic timerUnderflow
);
  localparam logic [15:0] SHOT_LOAD = 16'(ONESHOT_COUNT);
  localparam logic [15:0] SHOT_ONE = 16'h0001;
  localparam logic [15:0] SHOT_ZERO = 16'h0000;

  if (ONESHOT_COUNT < 1 || ONESHOT_COUNT > 65535) begin : g_bad_count
    $error("ONESHOT_COUNT out of range");
  end

  logic [4:0] prescale, next_prescale;
  logic [7:0] baudCnt, next_baudCnt;
  logic [15:0] shotCnt, next_shotCnt;
  logic extPrev, trigPrev, next_tick16, next_timerUnderflow;
  logic srcEn, trigEdge;

  // Count source pick, divider reload and one-shot countdown
  always_comb begin
    next_prescale = 5'(prescale + 5'h01);
    unique case (countSourceSelect)
      CS_F8: srcEn = (prescale[2:0] == PRE8_LAST);
      CS_F32: srcEn = (prescale == PRE32_LAST);
      default: srcEn = 1'b1;
    endcase
    if (clockDirection) begin
      srcEn = extClockSync && !extPrev; // External clock counts its rising edges [RULE_14]
    end
    next_baudCnt = baudCnt;
    next_tick16 = 1'b0;
    if (srcEn) begin
      if (baudCnt == BAUD_RST) begin
        next_baudCnt = baudDivider; // Divide by n+1 [RULE_14]
        next_tick16 = 1'b1;
      end else begin
        next_baudCnt = 8'(baudCnt - 8'h01);
      end
    end
    trigEdge = triggerSync && !trigPrev;
    next_shotCnt = shotCnt;
    next_timerUnderflow = 1'b0;
    if (trigEdge) begin
      next_shotCnt = SHOT_LOAD; // Retrigger restarts the shot [RULE_07]
    end else if (shotCnt != SHOT_ZERO) begin
      next_shotCnt = 16'(shotCnt - SHOT_ONE);
      next_timerUnderflow = (shotCnt == SHOT_ONE);
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prescale <= 5'h00;
      baudCnt <= BAUD_RST;
      shotCnt <= SHOT_ZERO;
      extPrev <= 1'b0;
      trigPrev <= 1'b0;
      tick16 <= 1'b0;
      timerUnderflow <= 1'b0;
    end else begin
      prescale <= next_prescale;
      baudCnt <= next_baudCnt;
      shotCnt <= next_shotCnt;
      extPrev <= extClockSync;
      trigPrev <= triggerSync;
      tick16 <= next_tick16;
      timerUnderflow <= next_timerUnderflow;
    end
  end
endmodule
`default_nettype wire

// >>> sim/uic_bus_collision_tb.sv
// Purpose: Self-checking bench for the bus collision channel
// Assumes: Divider 0 and undivided source, so one bit is 16 clocks
// Notes: Own transmission loops back through the bus node model
`timescale 1ns/1ps
`default_nettype none
module uic_bus_collision_tb;
  import uic_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pullLow = 0, trig = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, rxLine, txO, txOe, collIrq, e, txIrq, rxIrq;
  int fail_count = 0, comparisons = 0, q[$];
  int txIrqs = 0, rxIrqs = 0;
  logic [8:0] d;
  always #10 clk = ~clk;
  uic_bus_collision #(.CHANNEL(0), .ONESHOT_COUNT(4)) u_uic_bus_collision (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialRxPin(rxLine), .serialClockPin(1'b0),
    .timerTriggerInput(trig), .serialTxPinO(txO), .serialTxPinOe(txOe), .collisionIrq(collIrq),
    .txIrq(txIrq), .rxIrq(rxIrq));
  uic_bus_node u_uic_bus_node (.txO(txO), .txOe(txOe), .pullLow(pullLow), .line(rxLine));
  // Each interrupt pulse stands one cycle, so it is counted once
  always @(posedge clk) begin
    if (txIrq === 1'b1) txIrqs++;
    if (rxIrq === 1'b1) rxIrqs++;
  end
  // Verdict in one place; a hang also ends here
  task close_out;
    $display("fails=%0d compares=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    paddr <= a; pwrite <= w; pwdata <= wd; psel <= 1'b1; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin fail_count++; close_out(); end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk); // Idle edge so back-to-back calls never assign psel twice at once
  endtask
  // Bounded wait for a level on the transmit pin; a stuck design ends the run
  task waitv(input logic v);
    int n;
    for (n = 0; txO !== v && n < 2000; n++) @(posedge clk);
    if (n >= 2000) begin fail_count++; close_out(); end
  endtask
  initial begin
    void'($urandom(36));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(OFF_CTRL1, 0, 0); chk(r, 32'h2);
    apb(8'h40, 0, 0); chk({e, r[30:0]}, 32'h80000000);
    // Unassigned bits written as zero
    apb(OFF_MODE, 1, {29'h0, MODE_BUS_COLL});
    apb(OFF_IRQSEL, 1, 32'h2);
    // Last pass is armed first and then launched by a receive edge
    for (int i = 0; i < 4; i++) begin
      d = 9'($urandom);
      if (i == 2) d = 9'h100;
      if (i == 3) apb(OFF_SPECIAL, 1, 32'h40);
      q.push_back(d);
      apb(OFF_TXBUF, 1, {23'h0, d});
      apb(OFF_CTRL1, 1, 32'h5);
      if (i == 3) begin
        repeat (4) @(posedge clk);
        pullLow <= 1'b1;
        repeat (4) @(posedge clk);
        pullLow <= 1'b0;
      end
      waitv(1'b0);
      repeat (8) @(posedge clk);
      // Start bit then nine data bits, bit 0 first
      for (int b = 0; b < 10; b++) begin
        chk(txO, b == 0 ? 1'b0 : q[0][b-1]);
        if (b < 9) repeat (16) @(posedge clk);
      end
      repeat (40) @(posedge clk);
      apb(OFF_RXBUF, 0, 0); chk(r, {23'h0, q.pop_front()});
      apb(OFF_STATUS, 0, 0); chk(r, 32'h0);
    end
    // Dominant low from the other node while this channel sends ones
    apb(OFF_SPECIAL, 1, 32'h20);
    apb(OFF_TXBUF, 1, 32'h1FF);
    apb(OFF_CTRL1, 1, 32'h5);
    waitv(1'b0);
    repeat (20) @(posedge clk);
    pullLow <= 1'b1;
    repeat (40) @(posedge clk);
    pullLow <= 1'b0;
    chk(collIrq, 1'b1);
    apb(OFF_CTRL1, 0, 0); chk(r & 32'h1, 32'h0);
    repeat (200) @(posedge clk);
    apb(OFF_STATUS, 1, 32'h1);
    apb(OFF_STATUS, 0, 0); chk(r, 32'h0);
    // Timer-paced compare: the dominant low is gone again before the next bit edge
    apb(OFF_SPECIAL, 1, 32'h10);
    apb(OFF_TXBUF, 1, 32'h1FF);
    apb(OFF_CTRL1, 1, 32'h5);
    waitv(1'b0);
    repeat (18) @(posedge clk);
    pullLow <= 1'b1;
    trig <= 1'b1;
    repeat (9) @(posedge clk);
    pullLow <= 1'b0;
    trig <= 1'b0;
    repeat (2) @(posedge clk);
    chk(collIrq, 1'b1);
    repeat (200) @(posedge clk);
    // Two characters arrived unread, so the second one overran
    apb(OFF_RXBUF, 0, 0);
    chk(r[RB_OVERRUN], 1'b1);
    chk(r[RB_SUM], 1'b1);
    // Six loads with buffer-empty source, six characters received
    chk(txIrqs, 6);
    chk(rxIrqs, 6);
    // Inverted polarity idles the push-pull pin low
    apb(OFF_MODE, 1, {24'h0, 8'h86});
    repeat (2) @(posedge clk);
    chk(txO, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire

// >>> sim/uic_bus_node.sv
// Purpose: Other node on the shared wired serial bus
// Assumes: Pull-up on the line, so a released line reads high
// Notes: pullLow lets the bench force a dominant low to cause a collision
`timescale 1ns/1ps
`default_nettype none
module uic_bus_node (
  input wire logic txO,
  input wire logic txOe,
  input wire logic pullLow,
  output logic line
);
  // Wired line: released driver reads the pull-up level, any low dominates
  assign line = (txOe ? txO : 1'b1) & ~pullLow;
endmodule
`default_nettype wire
